// file: sram_host_ctrl.sv
/*
 * Host controller for an 8192 x 8 asynchronous static memory. Takes single
 * byte read and write requests and sequences the select, write and
 * output-gate strobes, address and data lines with clocked timing.
 * Assumes the memory sits directly on the pins and that its inputs settle
 * within one 25 ns clock period; data inputs are synchronous to mclk.
 * Every strobe phase lasts whole clock cycles, so a slower clock only makes
 * the phases longer; it never changes the order of the strobes.
 */
`timescale 1ns/1ps
module sram_host_ctrl
(
	input  wire logic                             mclk,          // Clock.
	input  wire logic                             rst,           // Sync reset.
	input  wire logic                             req,           // Request.
	input  wire logic                             req_write,     // 1 write.
	input  wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,      // Address.
	input  wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,     // Write byte.
	output logic                                  busy,          // Working.
	output logic                                  rd_valid,      // Read pulse.
	output logic [sram_host_pkg::DATA_W-1:0]      rd_data,       // Read byte.
	output logic                                  wr_done,       // Write pulse.
	output logic                                  sel_n,         // Select.
	output logic                                  write_n,       // Write.
	output logic                                  gate_n,        // Out gate.
	output logic [sram_host_pkg::ADDR_W-1:0]      word_address,  // Address.
	output logic [sram_host_pkg::DATA_W-1:0]      data_lines_o,  // Data out.
	output logic                                  data_lines_oe, // Drive data.
	input  wire logic [sram_host_pkg::DATA_W-1:0] data_lines_i   // Data in.
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		sram_host_pkg::state_t            st;
		logic                             busy;
		logic                             rd_valid;
		logic [sram_host_pkg::DATA_W-1:0] rd_data;
		logic                             wr_done;
		logic                             sel_n;
		logic                             write_n;
		logic                             gate_n;
		logic [sram_host_pkg::ADDR_W-1:0] addr;
		logic [sram_host_pkg::DATA_W-1:0] wdata;
		logic                             oe;
	} ctrl_state_t;

	localparam ctrl_state_t CTRL_RST = '{
		st:       sram_host_pkg::ST_IDLE,
		busy:     1'b0,
		rd_valid: 1'b0,
		rd_data:  8'h00,
		wr_done:  1'b0,
		sel_n:    1'b1,
		write_n:  1'b1,
		gate_n:   1'b1,
		addr:     13'h0000,
		wdata:    8'h00,
		oe:       1'b0
	};

	ctrl_state_t                       s_q;
	ctrl_state_t                       s_d;
	logic                              tmr_load;
	logic [sram_host_pkg::TIMER_W-1:0] tmr_value;
	logic                              tmr_done;

	strobe_timer u_timer
	(
		.mclk  (mclk),
		.rst   (rst),
		.load  (tmr_load),
		.value (tmr_value),
		.done  (tmr_done)
	);

	// ------------------------------------------------------------------
	// Timer load for each timed phase
	// ------------------------------------------------------------------
	// One table for both timed phases keeps the strobe widths side by side,
	// so a change of clock rate is checked in one place.
	// Phases that are not timed load zero, which leaves the timer idle.
	function automatic logic [sram_host_pkg::TIMER_W-1:0] phase_load
	(
		input sram_host_pkg::state_t st // Phase about to start.
	);
		logic [sram_host_pkg::TIMER_W-1:0] v;
		case (st)
			sram_host_pkg::ST_R_ACC:
				v = sram_host_pkg::ACCESS_LOAD;
			sram_host_pkg::ST_W_PULS:
				v = sram_host_pkg::WRITE_LOAD;
			default:
				v = sram_host_pkg::TIMER_RST;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// A read spends one cycle settling the address, then keeps select and
	// gate low for the access phase and samples the data lines on the edge
	// that raises select again. A write spends one cycle settling address
	// and data with the gate high, one overlap phase with select and write
	// strobe low, and one hold cycle in which the data is still driven.
	// Select and write strobe rise on the same edge, so whichever of them
	// the memory takes as the ending edge, the data is still valid there.
	always_comb
	begin
		s_d          = s_q;
		s_d.rd_valid = 1'b0;
		s_d.wr_done  = 1'b0;
		tmr_load     = 1'b0;
		tmr_value    = sram_host_pkg::TIMER_RST;
		case (s_q.st)
			sram_host_pkg::ST_IDLE:
			begin
				if (req)
				begin
					s_d.addr  = req_addr;
					s_d.wdata = req_wdata;
					if (req_write)
					begin
						// Gate stays high so the memory floats while we drive.
						s_d.gate_n = 1'b1;
						s_d.oe     = 1'b1;
						s_d.st     = sram_host_pkg::ST_W_SET;
					end
					else
						s_d.st = sram_host_pkg::ST_R_ADDR;
				end
			end
			sram_host_pkg::ST_R_ADDR:
			begin
				// Address has been stable for a full cycle already.
				s_d.sel_n   = 1'b0;
				s_d.gate_n  = 1'b0;
				s_d.write_n = 1'b1;
				s_d.st      = sram_host_pkg::ST_R_ACC;
				tmr_load    = 1'b1;
				tmr_value   = phase_load(s_d.st);
			end
			sram_host_pkg::ST_R_ACC:
			begin
				if (tmr_done)
				begin
					// The memory has driven the lines for the whole
					// select-low phase, so they are settled at this edge.
					s_d.rd_data  = data_lines_i;
					s_d.rd_valid = 1'b1;
					s_d.sel_n    = 1'b1;
					s_d.gate_n   = 1'b1;
					s_d.st       = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_W_SET:
			begin
				// Address and data settled a cycle before the overlap opens.
				s_d.sel_n   = 1'b0;
				s_d.write_n = 1'b0;
				s_d.st      = sram_host_pkg::ST_W_PULS;
				tmr_load    = 1'b1;
				tmr_value   = phase_load(s_d.st);
			end
			sram_host_pkg::ST_W_PULS:
			begin
				if (tmr_done)
				begin
					s_d.sel_n   = 1'b1;
					s_d.write_n = 1'b1;
					s_d.st      = sram_host_pkg::ST_W_HOLD;
				end
			end
			sram_host_pkg::ST_W_HOLD:
			begin
				// Data and address stay one cycle past the ending edge.
				s_d.oe      = 1'b0;
				s_d.wr_done = 1'b1;
				s_d.st      = sram_host_pkg::ST_IDLE;
			end
			default:
			begin
				// A corrupt state code drops to idle, strobes released.
				s_d = CTRL_RST;
			end
		endcase
		s_d.busy = (s_d.st != sram_host_pkg::ST_IDLE);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= CTRL_RST;
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	// Every pin is a flip-flop output, so the asynchronous memory never
	// sees a glitch between clock edges.
	assign busy          = s_q.busy;
	assign rd_valid      = s_q.rd_valid;
	assign rd_data       = s_q.rd_data;
	assign wr_done       = s_q.wr_done;
	assign sel_n         = s_q.sel_n;
	assign write_n       = s_q.write_n;
	assign gate_n        = s_q.gate_n;
	assign word_address  = s_q.addr;
	assign data_lines_o  = s_q.wdata;
	assign data_lines_oe = s_q.oe;

endmodule

// file: sram_host_pkg.sv
/*
 * Shared constants and types for the host-side controller of an 8192 x 8
 * asynchronous static memory: widths, strobe timings and their cycle counts.
 * Assumes a single 40 MHz system clock.
 */
package sram_host_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int ADDR_W  = 13;
	localparam int DATA_W  = 8;
	localparam int TIMER_W = 4;

	// ------------------------------------------------------------------
	// Timing, in nanoseconds, and derived clock counts
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int ACCESS_NS     = 10;
	localparam int WRITE_PULSE_MIN_GATE_LOW_NS  = 9;
	localparam int WRITE_PULSE_MIN_GATE_HIGH_NS = 8;

	// Least times round up to whole cycles, never below one.
	function automatic int min_cycles(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ACCESS_CYC = min_cycles(ACCESS_NS);
	// The longer of both figures is taken so the pulse is legal whatever
	// the gate level.
	localparam int WRITE_PULSE_CYC =
		(WRITE_PULSE_MIN_GATE_LOW_NS > WRITE_PULSE_MIN_GATE_HIGH_NS) ?
		min_cycles(WRITE_PULSE_MIN_GATE_LOW_NS) :
		min_cycles(WRITE_PULSE_MIN_GATE_HIGH_NS);

	localparam logic [TIMER_W-1:0] ACCESS_LOAD = TIMER_W'(ACCESS_CYC - 1);
	localparam logic [TIMER_W-1:0] WRITE_LOAD  = TIMER_W'(WRITE_PULSE_CYC - 1);
	localparam logic [TIMER_W-1:0] TIMER_RST   = 4'h0;

	// ------------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_R_ADDR = 6'h02,
		ST_R_ACC  = 6'h04,
		ST_W_SET  = 6'h08,
		ST_W_PULS = 6'h10,
		ST_W_HOLD = 6'h20
	} state_t;

endpackage

// file: sram_host_props.sv
/*
 * Checker for the memory host controller: strobe order and latencies.
 * Assumes only the controller ports and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sram_host_props
(
	input wire logic                             mclk,          // Clock.
	input wire logic                             rst,           // Reset.
	input wire logic                             req,           // Request.
	input wire logic                             req_write,     // Kind.
	input wire logic                             busy,          // Working.
	input wire logic                             rd_valid,      // Read done.
	input wire logic                             wr_done,       // Write done.
	input wire logic                             sel_n,         // Select.
	input wire logic                             write_n,       // Write.
	input wire logic                             gate_n,        // Gate.
	input wire logic [sram_host_pkg::ADDR_W-1:0] word_address,  // Address.
	input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_o,  // Data out.
	input wire logic                             data_lines_oe  // Drive.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rd_wr_high; !sel_n && !gate_n |-> write_n; endproperty
	a_rd_wr_high: assert property (p_rd_wr_high)
		else $error("write strobe low during read");
	property p_addr_first; $fell(sel_n) |-> $stable(word_address); endproperty
	a_addr_first: assert property (p_addr_first)
		else $error("address moved as select fell");
	property p_wr_sel; !write_n |-> !sel_n; endproperty
	a_wr_sel: assert property (p_wr_sel)
		else $error("write strobe without select");
	property p_data_hold;
		!write_n |=> data_lines_oe && $stable(data_lines_o);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("write data not held past write end");
	property p_pulse; $fell(write_n) |-> gate_n ##1 write_n; endproperty
	a_pulse: assert property (p_pulse)
		else $error("write pulse shape wrong");
	property p_oe_gate; data_lines_oe |-> gate_n; endproperty
	a_oe_gate: assert property (p_oe_gate)
		else $error("host drives while memory gated on");
	property p_rd_lat; req && !busy && !req_write |-> ##3 rd_valid; endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer latency wrong");
	property p_wr_lat;
		req && !busy && req_write |-> ##1 write_n ##1 !write_n ##2 wr_done;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write sequence wrong");
	c_rd: cover property (rd_valid);
	c_wr: cover property (wr_done);
	c_b2b: cover property (wr_done && req);
endmodule
bind sram_host_ctrl sram_host_props u_props (.mclk(mclk), .rst(rst),
	.req(req), .req_write(req_write), .busy(busy), .rd_valid(rd_valid),
	.wr_done(wr_done), .sel_n(sel_n), .write_n(write_n), .gate_n(gate_n),
	.word_address(word_address), .data_lines_o(data_lines_o),
	.data_lines_oe(data_lines_oe));

// file: sram_mem_model.sv
/*
 * Behavioural 8192 x 8 static memory with no clock and no reset.
 * Assumes the bench feeds it the host pins and reads back the data wire.
 */
`timescale 1ns/1ps
module sram_mem_model
(
	input wire logic        sel_n,   // Select.
	input wire logic        write_n, // Write strobe.
	input wire logic        gate_n,  // Output gate.
	input wire logic [12:0] addr,    // Address.
	input wire logic [7:0]  din,     // Host data.
	input wire logic        din_oe,  // Host drives.
	output logic     [7:0]  bus      // Wire level.
);
	logic [7:0] mem [0:8191];
	logic [7:0] last;
	logic       drive;
	assign drive = !sel_n && !gate_n && write_n;
	always @*
		if (!sel_n && !write_n)
			mem[addr] = din;
	// An undriven wire shows the inverse of its last value, so a stale
	// byte never passes for a real answer.
	always @(negedge drive)
		last = mem[addr];
	assign bus = drive ? mem[addr] : din_oe ? din : ~last;
endmodule

// file: strobe_timer.sv
/*
 * Down-counter that times strobe phases of the memory controller.
 * Assumes the loader asserts load for one cycle on entering a timed phase.
 */
`timescale 1ns/1ps
module strobe_timer
(
	input  wire logic                              mclk,  // System clock.
	input  wire logic                              rst,   // Sync reset.
	input  wire logic                              load,  // Start a phase.
	input  wire logic [sram_host_pkg::TIMER_W-1:0] value, // Cycles minus one.
	output logic                                   done   // Phase elapsed.
);

	typedef struct packed {
		logic [sram_host_pkg::TIMER_W-1:0] count;
	} timer_state_t;

	timer_state_t s_q;
	timer_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (load)
			s_d.count = value;
		else if (s_q.count != sram_host_pkg::TIMER_RST)
			s_d.count = s_q.count - 4'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= '{count: sram_host_pkg::TIMER_RST};
		else
			s_q <= s_d;
	end

	assign done = (s_q.count == sram_host_pkg::TIMER_RST) && !load;

endmodule

// file: tb_top.sv
/*
 * Self-checking bench for the memory host controller with a memory model.
 * Assumes a 40 MHz clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ps
module tb_top;
	logic mclk = 0, rst = 1, req = 0, req_write = 0;
	logic [12:0] req_addr = 13'h0000;
	logic [7:0] req_wdata = 8'h00, rd_data, data_lines_o, data_lines_i;
	logic busy, rd_valid, wr_done, sel_n, write_n, gate_n, data_lines_oe;
	logic [12:0] word_address, a;
	logic [7:0] shadow [0:8191];
	logic [21:0] exp_q [$];
	int err_total = 0, comparisons = 0;
	always #12.5 mclk = ~mclk;
	sram_host_ctrl dut (.mclk(mclk), .rst(rst), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
		.wr_done(wr_done), .sel_n(sel_n), .write_n(write_n), .gate_n(gate_n),
		.word_address(word_address), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
	sram_mem_model mem (.sel_n(sel_n), .write_n(write_n), .gate_n(gate_n),
		.addr(word_address), .din(data_lines_o), .din_oe(data_lines_oe),
		.bus(data_lines_i));
	// Results are {kind, address, byte}: kind 1 is a write.
	task automatic check_rd(input logic [21:0] got, input logic [21:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_wr(input logic [21:0] got, input logic [21:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t write %h expected %h", $time, got, exp);
		end
	endtask
	task automatic flag(input string why);
		err_total++;
		$display("[FAIL] %0t %s", $time, why);
	endtask
	task automatic results;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// A request held while busy must leave no trace in the results.
	task automatic op(input logic wr, input logic [12:0] ad, input bit hold);
		for (int n = 0; busy !== 1'b0; n++)
		begin
			if (n > 20)
			begin
				flag("controller stayed busy");
				results;
			end
			@(negedge mclk);
		end
		req = 1;
		req_write = wr;
		req_addr = ad;
		req_wdata = 8'($urandom);
		if (wr)
			shadow[ad] = req_wdata;
		exp_q.push_back({wr, ad, shadow[ad]});
		@(negedge mclk);
		if (hold)
		begin
			req_write = ~wr;
			req_addr = 13'($urandom);
			@(negedge mclk);
		end
		req = 0;
	endtask
	always @(negedge mclk)
		if (!rst && (rd_valid || wr_done))
		begin
			if (exp_q.size() == 0)
				flag("result with no request outstanding");
			else if (wr_done)
				check_wr({1'b1, word_address, mem.mem[word_address]},
					exp_q.pop_front());
			else
				check_rd({1'b0, word_address, rd_data}, exp_q.pop_front());
		end
	initial
	begin
		repeat (3000) @(posedge mclk);
		flag("run timed out");
		results;
	end
	initial
	begin
		void'($urandom(32'h3916b637));
		repeat (3) @(negedge mclk);
		rst = 0;
		op(1, 13'h0000, 0);
		op(1, 13'h1fff, 1);
		op(0, 13'h1fff, 0);
		op(0, 13'h0000, 1);
		for (int i = 0; i < 24; i++)
		begin
			a = 13'($urandom);
			op(1, a, i[0]);
			op(0, a, 0);
			op(1, a, 0);
			op(0, a, i[1]);
		end
		repeat (8) @(negedge mclk);
		check_wr(22'(exp_q.size()), 22'h000000);
		results;
	end
endmodule
